// [swc_link_partner.sv]
module swc_link_partner (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_slot_en,
   input wire logic i_slow,
   output logic o_slp_sym = 1'b0,
   output logic o_wur_sym = 1'b0,
   output logic o_sym_slot = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   // slow mode offers a slot every third cycle to stretch the line
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ph <= 2'h0;
         o_sym_slot <= 1'b0;
      end else begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         o_sym_slot <= i_slot_en && (!i_slow || ph == 2'h0);
      end
   end
   task automatic send(input logic w, input int n, input int gap);
      repeat (n) begin
         @(posedge i_clk);
         if (w) o_wur_sym <= 1'b1;
         else o_slp_sym <= 1'b1;
         @(posedge i_clk);
         o_wur_sym <= 1'b0;
         o_slp_sym <= 1'b0;
         repeat (gap - 1) @(posedge i_clk);
      end
   endtask
endmodule

// [swc_pkg.sv]
package swc_pkg;

   // ***************************************************************
   // bus and register map
   // ***************************************************************
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam logic [8:0] OFS_FWD_CTRL = 9'h184;
   localparam logic [8:0] OFS_TIMER_GAP = 9'h185;
   localparam logic [8:0] OFS_SLP_TX_CNT = 9'h187;
   localparam logic [8:0] OFS_WUR_TX_CNT = 9'h188;
   localparam logic [8:0] OFS_SLP_RX_THR = 9'h189;
   localparam logic [8:0] OFS_STATUS = 9'h190;
   localparam logic [8:0] OFS_RX_COUNTS = 9'h191;

   localparam logic [15:0] RST_FWD_CTRL = 16'h0223;
   localparam logic [15:0] RST_TIMER_GAP = 16'h0000;
   localparam logic [15:0] RST_SLP_TX_CNT = 16'h0000;
   localparam logic [15:0] RST_WUR_TX_CNT = 16'h0080;
   localparam logic [15:0] RST_SLP_RX_THR = 16'h0040;

   localparam logic [15:0] WMASK_FWD_CTRL = 16'h927F;
   localparam logic [15:0] WMASK_TIMER_GAP = 16'hE00F;
   localparam logic [15:0] WMASK_SLP_TX_CNT = 16'h83FF;
   localparam logic [15:0] WMASK_CNT10 = 16'h03FF;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int B_CLR_RX_WUR = 15;
   localparam int B_CLR_RX_SLP = 12;
   localparam int B_CLR_TX_WUR = 9;
   localparam int B_CLR_TX_SLP = 6;
   localparam int B_FWD_EN_PSV = 5;
   localparam int B_FWD_MAN = 4;
   localparam int B_FWD_WIDTH_LO = 2;
   localparam int B_FWD_EN_WUR = 1;
   localparam int B_FWD_EN_WUP = 0;
   localparam int B_WTX_SEL_LO = 13;
   localparam int B_GAP_WUR_LO = 2;
   localparam int B_GAP_SLP_LO = 0;
   localparam int B_STOP_ON_DONE = 15;
   localparam int CNT_W = 10;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_MHZ = 10;
   localparam int FWD_US0 = 50;
   localparam int FWD_US1 = 500;
   localparam int FWD_US2 = 2000;
   localparam int FWD_US3 = 20000;
   localparam int WTX_US0 = 1000;
   localparam int WTX_US1 = 700;
   localparam int WTX_US2 = 1300;
   localparam int WTX_US3 = 850;
   localparam int WTX_US4 = 1500;
   localparam int WTX_US5 = 2000;
   localparam int WTX_US6 = 2500;
   localparam int WTX_US7 = 3000;
   // symbol gap limits, code zero tightest
   localparam int GAP_US0 = 10;
   localparam int GAP_US1 = 20;
   localparam int GAP_US2 = 40;
   localparam int GAP_US3 = 80;
   localparam int GAP_W = 12;
   localparam int TMR_W = 24;
   localparam logic [11:0] GAP_CYC0 = 12'(GAP_US0 * CLK_MHZ);
   localparam logic [11:0] GAP_CYC1 = 12'(GAP_US1 * CLK_MHZ);
   localparam logic [11:0] GAP_CYC2 = 12'(GAP_US2 * CLK_MHZ);
   localparam logic [11:0] GAP_CYC3 = 12'(GAP_US3 * CLK_MHZ);

   typedef enum logic [0:0] {WUR_IDLE, WUR_SEND} swc_wur_st_t;

endpackage

// [swc_pulse_timer.sv]
module swc_pulse_timer #(
   parameter int W = 24
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_load,
   input wire logic [W-1:0] i_cycles,
   output logic o_busy
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic busy_ff;
   logic nxt_busy;

   // a load while busy restarts the full width
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      if (i_load && i_cycles != '0) begin
         nxt_cnt = i_cycles - W'(1);
         nxt_busy = 1'b1;
      end else if (busy_ff) begin
         if (cnt_ff == '0) begin
            nxt_busy = 1'b0;
         end else begin
            nxt_cnt = cnt_ff - W'(1);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end

   assign o_busy = busy_ff;

endmodule

// [swc_sleep_wake_cfg.sv]
// Function
// - receive-data clears received wake-request count when its clear bit 15 set
// - receive-data clears received sleep-symbol count when its clear bit 12 set
// - transmit-data clears sent wake-request count when bit 9 set, reset one
// - transmit-data clears sent sleep-symbol count when bit 6 set
// - state_a wake pulse forwards to wake pin only when bit 5 set
// - writing one to bit 4 fires wake forwarding; bit clears itself
// - wake forwarding pulse width codes: 50us, 500us, 2ms, 20ms
// - bit 1 enables forwarding on acknowledged received wake-request symbols
// - bit 0 enables forwarding on received wake-up pulses
// - wake-transmit dwell selected by three-bit code, 0.7ms to 3ms
// - wake-request acknowledged only when symbol gaps stay within bits 3-2 limit
// - sleep request acknowledged only when symbol gaps stay within bits 1-0 limit
// - stop-on-done bit halts sleep symbol sending at the configured count
// - sleep-transmit-done asserts after ten-bit count of sleep symbols sent
// - wake-request symbols sent equal ten-bit count, reset 128
// - sleep-received flag sets after threshold count, reset 64
//
// The plain strobed port was decided locally.
module swc_sleep_wake_cfg
   import swc_pkg::*;
#(
   parameter int unsigned FWD_CYC0 = FWD_US0 * CLK_MHZ,
   parameter int unsigned FWD_CYC1 = FWD_US1 * CLK_MHZ,
   parameter int unsigned FWD_CYC2 = FWD_US2 * CLK_MHZ,
   parameter int unsigned FWD_CYC3 = FWD_US3 * CLK_MHZ,
   parameter int unsigned WTX_CYC0 = WTX_US0 * CLK_MHZ,
   parameter int unsigned WTX_CYC1 = WTX_US1 * CLK_MHZ,
   parameter int unsigned WTX_CYC2 = WTX_US2 * CLK_MHZ,
   parameter int unsigned WTX_CYC3 = WTX_US3 * CLK_MHZ,
   parameter int unsigned WTX_CYC4 = WTX_US4 * CLK_MHZ,
   parameter int unsigned WTX_CYC5 = WTX_US5 * CLK_MHZ,
   parameter int unsigned WTX_CYC6 = WTX_US6 * CLK_MHZ,
   parameter int unsigned WTX_CYC7 = WTX_US7 * CLK_MHZ,
   parameter logic [9:0] WUR_ACK_CNT = 10'h008
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [swc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [swc_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_rx_data,
   input wire logic i_tx_data,
   input wire logic i_rx_slp_sym,
   input wire logic i_rx_wur_sym,
   input wire logic i_rx_wup,
   input wire logic i_state_a,
   input wire logic i_sym_slot,
   input wire logic i_tx_slp_req,
   input wire logic i_tx_wur_start,
   input wire logic i_wake_tx_start,
   output logic [swc_pkg::DATA_W-1:0] o_rdata,
   output logic o_wake_pin,
   output logic o_wake_tx_active,
   output logic o_tx_slp_sym,
   output logic o_tx_wur_sym,
   output logic o_tx_slp_done,
   output logic o_slp_recv,
   output logic o_wur_ack
);

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   function automatic logic [GAP_W-1:0] gap_limit(input logic [1:0] code);
      logic [GAP_W-1:0] r;
      r = GAP_CYC0;
      unique case (code)
         2'h0: r = GAP_CYC0;
         2'h1: r = GAP_CYC1;
         2'h2: r = GAP_CYC2;
         2'h3: r = GAP_CYC3;
      endcase
      return r;
   endfunction

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      return (v == '1) ? v : v + CNT_W'(1);
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************
   logic [15:0] fwd_ctrl_ff, nxt_fwd_ctrl;
   logic [15:0] timer_gap_ff, nxt_timer_gap;
   logic [15:0] slp_tx_cnt_ff, nxt_slp_tx_cnt;
   logic [15:0] wur_tx_cnt_ff, nxt_wur_tx_cnt;
   logic [15:0] slp_rx_thr_ff, nxt_slp_rx_thr;
   logic [15:0] rdata_ff, nxt_rdata;
   logic [CNT_W-1:0] rx_slp_cnt_ff, nxt_rx_slp_cnt;
   logic [CNT_W-1:0] rx_wur_cnt_ff, nxt_rx_wur_cnt;
   logic [CNT_W-1:0] tx_slp_cnt_ff, nxt_tx_slp_cnt;
   logic [CNT_W-1:0] tx_wur_cnt_ff, nxt_tx_wur_cnt;
   logic [GAP_W-1:0] slp_gap_ff, nxt_slp_gap;
   logic [GAP_W-1:0] wur_gap_ff, nxt_wur_gap;
   logic tx_slp_sym_ff, nxt_tx_slp_sym;
   logic tx_wur_sym_ff, nxt_tx_wur_sym;
   logic tx_slp_done_ff, nxt_tx_slp_done;
   logic slp_recv_ff, nxt_slp_recv;
   logic wur_ack_ff, nxt_wur_ack;
   swc_wur_st_t wur_st_ff, nxt_wur_st;

   logic fwd_fire;
   logic [TMR_W-1:0] fwd_cycles;
   logic [TMR_W-1:0] wtx_cycles;
   logic wake_busy;
   logic wtx_busy;

   // ***************************************************************
   // register bus
   // ***************************************************************
   always_comb begin
      nxt_fwd_ctrl = fwd_ctrl_ff;
      nxt_timer_gap = timer_gap_ff;
      nxt_slp_tx_cnt = slp_tx_cnt_ff;
      nxt_wur_tx_cnt = wur_tx_cnt_ff;
      nxt_slp_rx_thr = slp_rx_thr_ff;
      nxt_rdata = 16'h0000;
      // trigger bit lives exactly one cycle, then hardware drops it
      nxt_fwd_ctrl[B_FWD_MAN] = 1'b0;
      if (i_wr) begin
         unique case (i_addr)
            OFS_FWD_CTRL: nxt_fwd_ctrl = i_wdata & WMASK_FWD_CTRL;
            OFS_TIMER_GAP: nxt_timer_gap = i_wdata & WMASK_TIMER_GAP;
            OFS_SLP_TX_CNT: nxt_slp_tx_cnt = i_wdata & WMASK_SLP_TX_CNT;
            OFS_WUR_TX_CNT: nxt_wur_tx_cnt = i_wdata & WMASK_CNT10;
            OFS_SLP_RX_THR: nxt_slp_rx_thr = i_wdata & WMASK_CNT10;
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            OFS_FWD_CTRL: nxt_rdata = fwd_ctrl_ff;
            OFS_TIMER_GAP: nxt_rdata = timer_gap_ff;
            OFS_SLP_TX_CNT: nxt_rdata = slp_tx_cnt_ff;
            OFS_WUR_TX_CNT: nxt_rdata = wur_tx_cnt_ff;
            OFS_SLP_RX_THR: nxt_rdata = slp_rx_thr_ff;
            OFS_STATUS: nxt_rdata = {10'h000, wtx_busy, wake_busy, wur_ack_ff,
                                     slp_recv_ff, tx_slp_done_ff,
                                     (wur_st_ff == WUR_SEND)};
            OFS_RX_COUNTS: nxt_rdata = {6'h00, rx_slp_cnt_ff};
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fwd_ctrl_ff <= RST_FWD_CTRL;
         timer_gap_ff <= RST_TIMER_GAP;
         slp_tx_cnt_ff <= RST_SLP_TX_CNT;
         wur_tx_cnt_ff <= RST_WUR_TX_CNT;
         slp_rx_thr_ff <= RST_SLP_RX_THR;
         rdata_ff <= 16'h0000;
      end else begin
         fwd_ctrl_ff <= nxt_fwd_ctrl;
         timer_gap_ff <= nxt_timer_gap;
         slp_tx_cnt_ff <= nxt_slp_tx_cnt;
         wur_tx_cnt_ff <= nxt_wur_tx_cnt;
         slp_rx_thr_ff <= nxt_slp_rx_thr;
         rdata_ff <= nxt_rdata;
      end
   end

   // ***************************************************************
   // receive symbol counting with gap check
   // ***************************************************************
   always_comb begin
      nxt_rx_slp_cnt = rx_slp_cnt_ff;
      nxt_rx_wur_cnt = rx_wur_cnt_ff;
      nxt_slp_gap = (slp_gap_ff == '1) ? slp_gap_ff : slp_gap_ff + GAP_W'(1);
      nxt_wur_gap = (wur_gap_ff == '1) ? wur_gap_ff : wur_gap_ff + GAP_W'(1);
      if (i_rx_slp_sym) begin
         nxt_slp_gap = '0;
         // too long a pause breaks the run; the new symbol starts a fresh one
         if (rx_slp_cnt_ff != '0 &&
             slp_gap_ff >= gap_limit(timer_gap_ff[B_GAP_SLP_LO +: 2])) begin
            nxt_rx_slp_cnt = CNT_W'(1);
         end else begin
            nxt_rx_slp_cnt = sat_inc(rx_slp_cnt_ff);
         end
      end
      if (i_rx_wur_sym) begin
         nxt_wur_gap = '0;
         if (rx_wur_cnt_ff != '0 &&
             wur_gap_ff >= gap_limit(timer_gap_ff[B_GAP_WUR_LO +: 2])) begin
            nxt_rx_wur_cnt = CNT_W'(1);
         end else begin
            nxt_rx_wur_cnt = sat_inc(rx_wur_cnt_ff);
         end
      end
      // data wins over a symbol in the same cycle: the run is over
      if (i_rx_data && fwd_ctrl_ff[B_CLR_RX_SLP]) begin
         nxt_rx_slp_cnt = '0;
      end
      if (i_rx_data && fwd_ctrl_ff[B_CLR_RX_WUR]) begin
         nxt_rx_wur_cnt = '0;
      end
      nxt_slp_recv = (nxt_rx_slp_cnt != '0) &&
                     (nxt_rx_slp_cnt >= slp_rx_thr_ff[CNT_W-1:0]);
      nxt_wur_ack = (nxt_rx_wur_cnt != '0) && (nxt_rx_wur_cnt >= WUR_ACK_CNT);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rx_slp_cnt_ff <= '0;
         rx_wur_cnt_ff <= '0;
         slp_gap_ff <= '0;
         wur_gap_ff <= '0;
         slp_recv_ff <= 1'b0;
         wur_ack_ff <= 1'b0;
      end else begin
         rx_slp_cnt_ff <= nxt_rx_slp_cnt;
         rx_wur_cnt_ff <= nxt_rx_wur_cnt;
         slp_gap_ff <= nxt_slp_gap;
         wur_gap_ff <= nxt_wur_gap;
         slp_recv_ff <= nxt_slp_recv;
         wur_ack_ff <= nxt_wur_ack;
      end
   end

   // ***************************************************************
   // transmit symbol sequencing
   // ***************************************************************
   always_comb begin
      nxt_tx_slp_cnt = tx_slp_cnt_ff;
      nxt_tx_wur_cnt = tx_wur_cnt_ff;
      nxt_tx_slp_sym = 1'b0;
      nxt_tx_wur_sym = 1'b0;
      nxt_wur_st = wur_st_ff;
      if (i_tx_slp_req && i_sym_slot &&
          !(slp_tx_cnt_ff[B_STOP_ON_DONE] && tx_slp_done_ff)) begin
         nxt_tx_slp_sym = 1'b1;
         nxt_tx_slp_cnt = sat_inc(tx_slp_cnt_ff);
      end
      unique case (wur_st_ff)
         WUR_IDLE: begin
            if (i_tx_wur_start && wur_tx_cnt_ff[CNT_W-1:0] != '0) begin
               nxt_tx_wur_cnt = '0;
               nxt_wur_st = WUR_SEND;
            end
         end
         WUR_SEND: begin
            if (i_sym_slot) begin
               nxt_tx_wur_sym = 1'b1;
               nxt_tx_wur_cnt = sat_inc(tx_wur_cnt_ff);
               if (sat_inc(tx_wur_cnt_ff) >= wur_tx_cnt_ff[CNT_W-1:0]) begin
                  nxt_wur_st = WUR_IDLE;
               end
            end
         end
      endcase
      if (i_tx_data && fwd_ctrl_ff[B_CLR_TX_SLP]) begin
         nxt_tx_slp_cnt = '0;
      end
      // clearing mid-burst lengthens it: the full count is sent after the data
      if (i_tx_data && fwd_ctrl_ff[B_CLR_TX_WUR]) begin
         nxt_tx_wur_cnt = '0;
      end
      nxt_tx_slp_done = nxt_tx_slp_cnt >= slp_tx_cnt_ff[CNT_W-1:0];
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_slp_cnt_ff <= '0;
         tx_wur_cnt_ff <= '0;
         tx_slp_sym_ff <= 1'b0;
         tx_wur_sym_ff <= 1'b0;
         tx_slp_done_ff <= 1'b0;
         wur_st_ff <= WUR_IDLE;
      end else begin
         tx_slp_cnt_ff <= nxt_tx_slp_cnt;
         tx_wur_cnt_ff <= nxt_tx_wur_cnt;
         tx_slp_sym_ff <= nxt_tx_slp_sym;
         tx_wur_sym_ff <= nxt_tx_wur_sym;
         tx_slp_done_ff <= nxt_tx_slp_done;
         wur_st_ff <= nxt_wur_st;
      end
   end

   // ***************************************************************
   // wake forwarding and wake-transmit dwell
   // ***************************************************************
   always_comb begin
      fwd_fire = fwd_ctrl_ff[B_FWD_MAN];
      if (nxt_wur_ack && !wur_ack_ff && fwd_ctrl_ff[B_FWD_EN_WUR]) begin
         fwd_fire = 1'b1;
      end
      if (i_rx_wup && fwd_ctrl_ff[B_FWD_EN_WUP] &&
          (!i_state_a || fwd_ctrl_ff[B_FWD_EN_PSV])) begin
         fwd_fire = 1'b1;
      end
      unique case (fwd_ctrl_ff[B_FWD_WIDTH_LO +: 2])
         2'h0: fwd_cycles = TMR_W'(FWD_CYC0);
         2'h1: fwd_cycles = TMR_W'(FWD_CYC1);
         2'h2: fwd_cycles = TMR_W'(FWD_CYC2);
         2'h3: fwd_cycles = TMR_W'(FWD_CYC3);
      endcase
      unique case (timer_gap_ff[B_WTX_SEL_LO +: 3])
         3'h0: wtx_cycles = TMR_W'(WTX_CYC0);
         3'h1: wtx_cycles = TMR_W'(WTX_CYC1);
         3'h2: wtx_cycles = TMR_W'(WTX_CYC2);
         3'h3: wtx_cycles = TMR_W'(WTX_CYC3);
         3'h4: wtx_cycles = TMR_W'(WTX_CYC4);
         3'h5: wtx_cycles = TMR_W'(WTX_CYC5);
         3'h6: wtx_cycles = TMR_W'(WTX_CYC6);
         3'h7: wtx_cycles = TMR_W'(WTX_CYC7);
      endcase
   end

   swc_pulse_timer #(
      .W(TMR_W)
   ) u_fwd_tmr (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(fwd_fire),
      .i_cycles(fwd_cycles),
      .o_busy(wake_busy)
   );

   swc_pulse_timer #(
      .W(TMR_W)
   ) u_wtx_tmr (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(i_wake_tx_start),
      .i_cycles(wtx_cycles),
      .o_busy(wtx_busy)
   );

   assign o_rdata = rdata_ff;
   assign o_wake_pin = wake_busy;
   assign o_wake_tx_active = wtx_busy;
   assign o_tx_slp_sym = tx_slp_sym_ff;
   assign o_tx_wur_sym = tx_wur_sym_ff;
   assign o_tx_slp_done = tx_slp_done_ff;
   assign o_slp_recv = slp_recv_ff;
   assign o_wur_ack = wur_ack_ff;

endmodule

// [swc_sleep_wake_cfg_properties.sv]
module swc_sleep_wake_cfg_properties
   import swc_pkg::*;
(
   input logic i_clk,
   input logic i_sys_rst,
   input logic [swc_pkg::ADDR_W-1:0] i_addr,
   input logic [swc_pkg::DATA_W-1:0] i_wdata,
   input logic i_wr,
   input logic i_rx_data,
   input logic i_tx_data,
   input logic i_rx_slp_sym,
   input logic i_rx_wur_sym,
   input logic i_rx_wup,
   input logic i_sym_slot,
   input logic i_tx_slp_req,
   input logic i_wake_tx_start,
   input logic o_wake_pin,
   input logic o_wake_tx_active,
   input logic o_tx_slp_sym,
   input logic o_tx_wur_sym,
   input logic o_tx_slp_done,
   input logic o_slp_recv,
   input logic o_wur_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] sh_ff;
   logic [2:0] nxt_sh;
   // shadow of the receive clear and stop controls
   always_comb begin
      nxt_sh = sh_ff;
      if (i_wr && i_addr == OFS_FWD_CTRL) begin
         nxt_sh[0] = i_wdata[B_CLR_RX_WUR];
         nxt_sh[1] = i_wdata[B_CLR_RX_SLP];
      end
      if (i_wr && i_addr == OFS_SLP_TX_CNT) begin
         nxt_sh[2] = i_wdata[B_STOP_ON_DONE];
      end
   end
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sh_ff <= 3'h0;
      end else begin
         sh_ff <= nxt_sh;
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   AST_MAN_FIRE: assert property (
      i_wr && i_addr == OFS_FWD_CTRL && i_wdata[B_FWD_MAN] |-> ##2 o_wake_pin)
      else $error("manual trigger no pulse");
   AST_PIN_CAUSE: assert property (
      $rose(o_wake_pin) |-> $past(i_wr, 2) || $past(i_rx_wup) || $past(i_rx_wup, 2)
         || o_wur_ack || $past(o_wur_ack))
      else $error("wake pulse uncaused");
   AST_WTX_START: assert property (
      i_wake_tx_start |=> o_wake_tx_active)
      else $error("dwell did not start");
   AST_SLP_CAUSE: assert property (
      o_tx_slp_sym |-> $past(i_tx_slp_req && i_sym_slot))
      else $error("sleep symbol unrequested");
   AST_WUR_CAUSE: assert property (
      o_tx_wur_sym |-> $past(i_sym_slot))
      else $error("wake symbol without slot");
   AST_SLP_STOP: assert property (
      sh_ff[2] && $past(o_tx_slp_done) && !$past(i_wr) && !$past(i_tx_data) |-> !o_tx_slp_sym)
      else $error("sleep symbol after stop");
   AST_ACK_CAUSE: assert property (
      $rose(o_wur_ack) |-> $past(i_rx_wur_sym) || $past(i_rx_wur_sym, 2))
      else $error("wake ack without symbol");
   AST_RECV_CAUSE: assert property (
      $rose(o_slp_recv) |-> $past(i_rx_slp_sym) || $past(i_rx_slp_sym, 2) || $past(i_wr)
         || $past(i_wr, 2))
      else $error("sleep flag without symbol");
   AST_RX_WUR_CLR: assert property (
      sh_ff[0] && i_rx_data ##1 !i_rx_wur_sym |=> !o_wur_ack)
      else $error("wake count not cleared");
   AST_RX_SLP_CLR: assert property (
      sh_ff[1] && i_rx_data ##1 !i_rx_slp_sym |=> !o_slp_recv)
      else $error("sleep count not cleared");
   COV_ACK: cover property ($rose(o_wur_ack));
   COV_DONE: cover property ($rose(o_tx_slp_done));
   COV_PIN: cover property ($rose(o_wake_pin));
endmodule

// [test_sleep_wake_signaling_config.sv]
module test_sleep_wake_signaling_config;
   timeunit 1ns;
   timeprecision 1ns;
   import swc_pkg::*;
   typedef struct {logic [8:0] a; logic [15:0] d; logic [15:0] e;} swc_row_t;
   localparam int FW[4] = '{5, 10, 20, 40};
   localparam int WT[8] = '{10, 11, 12, 13, 14, 15, 16, 17};
   localparam logic [9:0] ACK = 10'h008;
   localparam logic [4:0] RXD = 5'h10, TXD = 5'h08, WUP = 5'h04, WST = 5'h02, DWL = 5'h01;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_state_a = 1'b0;
   logic i_tx_slp_req = 1'b0, slot_en = 1'b0, slow = 1'b0, seen = 1'b0;
   logic [8:0] i_addr = 9'h000;
   logic [15:0] i_wdata = 16'h0000, rdv;
   logic [4:0] pv = 5'h00;
   wire logic i_rx_data, i_tx_data, i_rx_wup, i_tx_wur_start, i_wake_tx_start;
   wire logic i_rx_slp_sym, i_rx_wur_sym, i_sym_slot;
   logic [15:0] o_rdata;
   logic o_wake_pin, o_wake_tx_active, o_tx_slp_sym, o_tx_wur_sym;
   logic o_tx_slp_done, o_slp_recv, o_wur_ack;
   int err_total = 0, checks_done = 0, cyc = 0, ns = 0, nw = 0, n;
   swc_row_t regs[7] = '{'{9'h184, 16'hFFEF, 16'h926F}, '{9'h185, 16'hFFFF, 16'hE00F},
      '{9'h187, 16'hFFFF, 16'h83FF}, '{9'h188, 16'hFFFF, 16'h03FF},
      '{9'h189, 16'hFFFF, 16'h03FF}, '{9'h186, 16'hFFFF, 16'h0000},
      '{9'h18A, 16'hFFFF, 16'h0000}};
   swc_row_t wups[4] = '{'{9'h001, 16'h0223, 16'h0001}, '{9'h001, 16'h0203, 16'h0000},
      '{9'h000, 16'h0203, 16'h0001}, '{9'h000, 16'h0222, 16'h0000}};
   logic [15:0] rsv[5] = '{RST_FWD_CTRL, RST_TIMER_GAP, RST_SLP_TX_CNT, RST_WUR_TX_CNT,
      RST_SLP_RX_THR};
   assign {i_rx_data, i_tx_data, i_rx_wup, i_tx_wur_start, i_wake_tx_start} = pv;
   always #50 i_clk = ~i_clk;
   swc_sleep_wake_cfg #(
      .FWD_CYC0(FW[0]), .FWD_CYC1(FW[1]), .FWD_CYC2(FW[2]), .FWD_CYC3(FW[3]),
      .WTX_CYC0(WT[0]), .WTX_CYC1(WT[1]), .WTX_CYC2(WT[2]), .WTX_CYC3(WT[3]),
      .WTX_CYC4(WT[4]), .WTX_CYC5(WT[5]), .WTX_CYC6(WT[6]), .WTX_CYC7(WT[7]),
      .WUR_ACK_CNT(ACK)
   ) i_swc_sleep_wake_cfg (
      .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_rx_data, .i_tx_data,
      .i_rx_slp_sym, .i_rx_wur_sym, .i_rx_wup, .i_state_a, .i_sym_slot, .i_tx_slp_req,
      .i_tx_wur_start, .i_wake_tx_start, .o_rdata, .o_wake_pin, .o_wake_tx_active,
      .o_tx_slp_sym, .o_tx_wur_sym, .o_tx_slp_done, .o_slp_recv, .o_wur_ack
   );
   swc_link_partner i_partner (.i_clk, .i_sys_rst, .i_slot_en(slot_en), .i_slow(slow),
      .o_slp_sym(i_rx_slp_sym), .o_wur_sym(i_rx_wur_sym), .o_sym_slot(i_sym_slot));
   task automatic summarize();
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge i_clk);
      pv <= m;
      @(posedge i_clk);
      pv <= 5'h00;
   endtask
   task automatic do_reset();
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      tick(1);
   endtask
   task automatic hi_len(input logic w, output int k);
      int t;
      k = 0;
      t = 0;
      #1;
      while (!(w ? o_wake_tx_active : o_wake_pin) && t < 60) begin
         @(posedge i_clk);
         #1 t++;
      end
      while ((w ? o_wake_tx_active : o_wake_pin) && k < 500) begin
         @(posedge i_clk);
         #1 k++;
      end
   endtask
   always @(posedge i_clk) begin
      cyc++;
      ns += o_tx_slp_sym;
      nw += o_tx_wur_sym;
      seen |= o_wake_pin;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      do_reset();
      foreach (regs[r]) begin
         wr(regs[r].a, regs[r].d);
         rd(regs[r].a, rdv);
         chk("register", rdv, regs[r].e);
      end
      do_reset();
      foreach (rsv[r]) begin
         rd(regs[r].a, rdv);
         chk("reset value", rdv, rsv[r]);
      end
      for (int c = 0; c < 4; c++) begin
         wr(OFS_FWD_CTRL, RST_FWD_CTRL | 16'h0010 | 16'(c << 2));
         hi_len(1'b0, n);
         chk("wake width", n, FW[c]);
         rd(OFS_FWD_CTRL, rdv);
         chk("manual bit", rdv[4], 1'b0);
      end
      for (int c = 0; c < 8; c++) begin
         wr(OFS_TIMER_GAP, 16'(c << 13));
         pulse(DWL);
         hi_len(1'b1, n);
         chk("dwell", n, WT[c]);
      end
      foreach (wups[r]) begin
         wr(OFS_FWD_CTRL, wups[r].d);
         i_state_a <= wups[r].a[0];
         tick(1);
         seen = 1'b0;
         pulse(WUP);
         tick(8);
         chk("wake pulse fwd", seen, wups[r].e[0]);
      end
      do_reset();
      seen = 1'b0;
      i_partner.send(1'b1, ACK, 50);
      tick(3);
      chk("wur ack", o_wur_ack, 1'b1);
      chk("wur fwd", seen, 1'b1);
      wr(OFS_FWD_CTRL, 16'h8221);
      pulse(RXD);
      tick(3);
      chk("wur cleared", o_wur_ack, 1'b0);
      seen = 1'b0;
      i_partner.send(1'b1, ACK, 50);
      tick(3);
      chk("wur ack", o_wur_ack, 1'b1);
      chk("wur fwd off", seen, 1'b0);
      pulse(RXD);
      i_partner.send(1'b1, ACK, 150);
      tick(3);
      chk("wur wide gap", o_wur_ack, 1'b0);
      wr(OFS_TIMER_GAP, 16'h0004);
      pulse(RXD);
      i_partner.send(1'b1, ACK, 150);
      tick(3);
      chk("wur gap code 1", o_wur_ack, 1'b1);
      wr(OFS_SLP_RX_THR, 16'h0004);
      wr(OFS_FWD_CTRL, 16'h1223);
      i_partner.send(1'b0, 3, 50);
      tick(3);
      chk("slp below thr", o_slp_recv, 1'b0);
      i_partner.send(1'b0, 1, 50);
      tick(3);
      chk("slp at thr", o_slp_recv, 1'b1);
      pulse(RXD);
      tick(3);
      chk("slp cleared", o_slp_recv, 1'b0);
      i_partner.send(1'b0, 4, 150);
      tick(3);
      chk("slp wide gap", o_slp_recv, 1'b0);
      wr(OFS_FWD_CTRL, 16'h0263);
      wr(OFS_SLP_TX_CNT, 16'h8003);
      tick(1);
      ns = 0;
      @(posedge i_clk);
      slow <= 1'b1;
      slot_en <= 1'b1;
      i_tx_slp_req <= 1'b1;
      tick(40);
      chk("slp sent", ns, 3);
      chk("slp done", o_tx_slp_done, 1'b1);
      ns = 0;
      pulse(TXD);
      tick(40);
      chk("slp after clear", ns, 3);
      wr(OFS_SLP_TX_CNT, 16'h0003);
      slow <= 1'b0;
      tick(1);
      ns = 0;
      tick(20);
      chk("slp no stop", ns >= 19, 1'b1);
      @(posedge i_clk);
      i_tx_slp_req <= 1'b0;
      slot_en <= 1'b0;
      wr(OFS_WUR_TX_CNT, 16'h0005);
      tick(2);
      nw = 0;
      pulse(WST);
      slot_en <= 1'b1;
      tick(30);
      chk("wur sent", nw, 5);
      @(posedge i_clk);
      slot_en <= 1'b0;
      tick(2);
      nw = 0;
      pulse(WST);
      slot_en <= 1'b1;
      repeat (2) @(posedge i_clk);
      slot_en <= 1'b0;
      tick(3);
      pulse(TXD);
      slot_en <= 1'b1;
      tick(30);
      chk("wur restart", nw, 7);
      summarize();
   end
endmodule
bind swc_sleep_wake_cfg swc_sleep_wake_cfg_properties i_swc_sleep_wake_cfg_properties (
   .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rx_data, .i_tx_data, .i_rx_slp_sym,
   .i_rx_wur_sym, .i_rx_wup, .i_sym_slot, .i_tx_slp_req, .i_wake_tx_start, .o_wake_pin,
   .o_wake_tx_active, .o_tx_slp_sym, .o_tx_wur_sym, .o_tx_slp_done, .o_slp_recv, .o_wur_ack
);
